// ### timer16_counter_access_tb.sv
// self-checking bench for the three-unit timer block
`timescale 1ns/100ps
module timer16_counter_access_tb;
    import tmr16_pkg::*;
    typedef struct packed {
        tmr16_addr_t lo;
        tmr16_word_t v;
        tmr16_word_t e;
    } tmr16_row_s;
    localparam tmr16_row_s ROWS [5] = '{'{8'h48, 16'hFFFF, 16'hFFFF}, '{8'h50, 16'hA55A, 16'hA55A},
        '{8'h98, 16'h1234, 16'h1234}, '{8'h20, 16'hBEEF, 16'hBEEF}, '{8'h88, 16'h01FF, 16'h01FF}};
    logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    tmr16_addr_t       s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb, presc;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic [2:0]        ext_pin, cap_stb, ack, top, zero, ovf;
    tmr16_word_t [2:0] cnt;
    tmr16_byte_t       b;
    tmr16_word_t       w;
    int                err_count, check_count;
    tmr16_cpu_model cpu (.*);
    tmr16_top DUT (.*, .presc_tick(presc), .ext_clk_pin(ext_pin), .capture_strobe(cap_stb), .overflow_ack(ack),
        .counter_value(cnt), .compare_a_value(), .compare_b_value(), .capture_value(), .waveform_mode_bits(),
        .timer_control_a(), .timer_control_b(), .top_reached(top), .zero_reached(zero), .overflow_flag(ovf));
    // 25 mhz clock
    always #20 aclk = ~aclk;
    // compare and count
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // verdict and end of run
    task automatic final_report;
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // n spaced prescaler ticks
    task automatic tk(input int n);
        repeat (n) begin
            presc <= 4'h1;
            @(posedge aclk);
            presc <= 4'h0;
            repeat (3) @(posedge aclk);
        end
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        final_report;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {aclk, aresetn, presc, ext_pin, cap_stb, ack, err_count, check_count} = '0;
        repeat (10) @(posedge aclk);
        chk("rst flags", {7'h00, top, zero, ovf}, 16'h0038);
        aresetn <= 1'h1;
        foreach (ROWS[i]) begin
            cpu.wr16(ROWS[i].lo, ROWS[i].v);
            cpu.rd16(ROWS[i].lo, w);
            chk("row", w, ROWS[i].e);
        end
        // compare high reads bypass the shared latch
        cpu.wr16(8'h10, 16'h7E81);
        cpu.wr16(8'h08, 16'h01FF);
        cpu.rd(8'h08, b, r);
        cpu.rd(8'h14, b, r);
        chk("cmp hi", {8'h00, b}, 16'h007E);
        cpu.rd(8'h0C, b, r);
        chk("latch", {8'h00, b}, 16'h0001);
        // lone high write, then low commit
        cpu.wr(8'h0C, 8'h55, r);
        chk("hi only", cnt[0], 16'h01FF);
        cpu.rd(8'h0C, b, r);
        chk("latch", {8'h00, b}, 16'h0055);
        cpu.wr(8'h08, 8'h02, r);
        chk("commit", cnt[0], 16'h5502);
        cpu.rd(8'h20, b, r);
        cpu.rd(8'h0C, b, r);
        chk("shared", {8'h00, b}, 16'h00BE);
        // dual slope, overflow at zero, write-one clear
        cpu.wr16(8'h10, 16'h0003);
        cpu.wr16(8'h08, 16'h0002);
        cpu.wr(8'h00, 8'h01, r);
        cpu.wr(8'h04, 8'h12, r);
        tk(1);
        chk("top", 16'(top[0]), 16'h0001);
        tk(1);
        chk("down", cnt[0], 16'h0002);
        tk(2);
        chk("zero", 16'(zero[0]), 16'h0001);
        tk(1);
        chk("ovf", 16'(ovf[0]), 16'h0001);
        cpu.wr(8'h04, 8'h10, r);
        cpu.wr(8'h28, 8'h01, r);
        chk("w1c", 16'(ovf[0]), 16'h0000);
        // fixed maximum wraps to zero, ack clears, stopped unit holds
        cpu.wr(8'h44, 8'h02, r);
        tk(1);
        chk("wrap", cnt[1], 16'h0000);
        chk("ovf1", 16'(ovf[1]), 16'h0001);
        cpu.wr(8'h44, 8'h00, r);
        ack <= 3'h2;
        @(posedge aclk);
        ack <= 3'h0;
        @(posedge aclk);
        chk("ack", 16'(ovf[1]), 16'h0000);
        tk(2);
        chk("stop", cnt[1], 16'h0000);
        // write beats counting every clock
        cpu.wr(8'h84, 8'h01, r);
        cpu.wr16(8'h88, 16'h1234);
        #1;
        chk("wins", cnt[2], 16'h1235);
        @(posedge aclk);
        cpu.rd(8'h2C, b, r);
        chk("unmapped", {14'h0000, r}, 16'h0002);
        cpu.wr(8'hC0, 8'h01, r);
        chk("no unit", {14'h0000, r}, 16'h0002);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("rerst", cnt[2], 16'h0000);
        final_report;
    end
endmodule

// ### tmr16_counter.sv
// one 16-bit up/down counter core with load, clear and end detection
`timescale 1ns/100ps
module tmr16_counter #(
    parameter tmr16_pkg::tmr16_word_t FIXED_MAX = `TMR16_FIXED_MAX
) (
    input wire logic aclk,
    input wire logic aresetn,
    tmr16_if.core    cif
);
    import tmr16_pkg::*;

    typedef struct packed {
        tmr16_word_t cnt;
        logic        down;
    } tmr16_cnt_s;

    tmr16_cnt_s  st_reg;
    tmr16_cnt_s  st_next;
    tmr16_word_t top_val;
    logic        dual;
    logic        ctc;

    if (FIXED_MAX == 16'h0000) begin : g_chk
        $error("fixed maximum must be nonzero");
    end

    // mode class lookup
    function automatic logic in_mask(input tmr16_mode_t m, input logic [15:0] mask);
        in_mask = mask[m];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state: cpu load beats tick, tick steps or clears
    always_comb begin
        top_val = in_mask(cif.mode, `TMR16_TOPA_MASK) ? cif.cmp_a : FIXED_MAX;
        dual    = in_mask(cif.mode, `TMR16_DUAL_MASK);
        ctc     = in_mask(cif.mode, `TMR16_CTC_MASK);
        st_next = st_reg;
        cif.ovf_evt = 1'b0;
        if (cif.load) begin
            st_next.cnt = cif.load_val;
        end else if (cif.tick) begin
            if (dual) begin
                cif.ovf_evt = (st_reg.cnt == `TMR16_RST_WORD);
                if (!st_reg.down && st_reg.cnt >= top_val) begin
                    st_next.down = 1'b1;
                    st_next.cnt  = st_reg.cnt - 16'h0001;
                end else if (st_reg.down && st_reg.cnt == `TMR16_RST_WORD) begin
                    st_next.down = 1'b0;
                    st_next.cnt  = st_reg.cnt + 16'h0001;
                end else if (st_reg.down) begin
                    st_next.cnt  = st_reg.cnt - 16'h0001;
                end else begin
                    st_next.cnt  = st_reg.cnt + 16'h0001;
                end
            end else begin
                st_next.down = 1'b0;
                cif.ovf_evt  = ctc ? (st_reg.cnt == FIXED_MAX) : (st_reg.cnt >= top_val);
                if (st_reg.cnt >= top_val) begin
                    st_next.cnt = `TMR16_RST_WORD;
                end else begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // end indications
    assign cif.cnt      = st_reg.cnt;
    assign cif.top_hit  = (st_reg.cnt == top_val);
    assign cif.zero_hit = (st_reg.cnt == `TMR16_RST_WORD);
endmodule

// ### tmr16_cpu_model.sv
// axi4-lite master standing in for the cpu on the register bus
`timescale 1ns/100ps
module tmr16_cpu_model (
    input  wire logic              aclk,
    output tmr16_pkg::tmr16_addr_t s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [31:0]            s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    output logic                   s_axi_bready,
    output tmr16_pkg::tmr16_addr_t s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [31:0]       s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready
);
    import tmr16_pkg::*;
    // idle bus; responses are always accepted at once
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h07;
    end
    // byte write, each channel dropped when taken
    task automatic wr(input tmr16_addr_t a, input tmr16_byte_t d, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'h0;
        wd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    // one byte read
    task automatic rd(input tmr16_addr_t a, output tmr16_byte_t d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
    endtask
    // word write, high byte first
    task automatic wr16(input tmr16_addr_t lo, input tmr16_word_t v);
        logic [1:0] r;
        wr(lo + 8'h04, v[15:8], r);
        wr(lo, v[7:0], r);
    endtask
    // word read, low byte first
    task automatic rd16(input tmr16_addr_t lo, output tmr16_word_t v);
        logic [1:0] r;
        rd(lo, v[7:0], r);
        rd(lo + 8'h04, v[15:8], r);
    endtask
endmodule

// ### tmr16_defs.svh
// offsets, field positions, reset values and mode masks of the timer block
`ifndef TMR16_DEFS_SVH
`define TMR16_DEFS_SVH
`define TMR16_N          3
`define TMR16_AW         8
`define TMR16_IDX_LSB    6
`define TMR16_OFS_CTRL_A 6'h00
`define TMR16_OFS_CTRL_B 6'h04
`define TMR16_OFS_CNT_L  6'h08
`define TMR16_OFS_CNT_H  6'h0C
`define TMR16_OFS_CMPA_L 6'h10
`define TMR16_OFS_CMPA_H 6'h14
`define TMR16_OFS_CMPB_L 6'h18
`define TMR16_OFS_CMPB_H 6'h1C
`define TMR16_OFS_CAP_L  6'h20
`define TMR16_OFS_CAP_H  6'h24
`define TMR16_OFS_FLAG   6'h28
`define TMR16_CS_LSB     0
`define TMR16_WGM_HI_LSB 3
`define TMR16_WGM_LO_LSB 0
`define TMR16_OVF_BIT    0
`define TMR16_CS_STOP    3'h0
`define TMR16_CS_SYS     3'h1
`define TMR16_CS_PRE     3'h2
`define TMR16_CS_FALL    3'h6
`define TMR16_CS_RISE    3'h7
`define TMR16_RST_BYTE   8'h00
`define TMR16_RST_WORD   16'h0000
`define TMR16_FIXED_MAX  16'hFFFF
`define TMR16_TOPA_MASK  16'h8A10
`define TMR16_DUAL_MASK  16'h0F0E
`define TMR16_CTC_MASK   16'h1010
`define TMR16_OKAY       2'h0
`define TMR16_SLVERR     2'h2
`endif

// ### tmr16_if.sv
// link between the register side and one counter core
`timescale 1ns/100ps
interface tmr16_if;
    import tmr16_pkg::*;
    logic        tick;
    logic        load;
    tmr16_word_t load_val;
    tmr16_mode_t mode;
    tmr16_word_t cmp_a;
    tmr16_word_t cnt;
    logic        top_hit;
    logic        zero_hit;
    logic        ovf_evt;
    modport ctl  (output tick, load, load_val, mode, cmp_a,
                  input cnt, top_hit, zero_hit, ovf_evt);
    modport core (input tick, load, load_val, mode, cmp_a,
                  output cnt, top_hit, zero_hit, ovf_evt);
endinterface

// ### tmr16_pkg.sv
// types shared by the timer block
package tmr16_pkg;
`include "tmr16_defs.svh"
    typedef logic [7:0]  tmr16_byte_t;
    typedef logic [15:0] tmr16_word_t;
    typedef logic [3:0]  tmr16_mode_t;
    typedef logic [`TMR16_AW-1:0] tmr16_addr_t;
    typedef enum {
        REG_CTRL_A, REG_CTRL_B, REG_CNT_L, REG_CNT_H, REG_CMPA_L, REG_CMPA_H,
        REG_CMPB_L, REG_CMPB_H, REG_CAP_L, REG_CAP_H, REG_FLAG, REG_NONE
    } tmr16_reg_e;
    typedef struct packed {
        tmr16_byte_t ctrl_a;
        tmr16_byte_t ctrl_b;
        tmr16_byte_t temp;
        tmr16_word_t cmp_a;
        tmr16_word_t cmp_b;
        tmr16_word_t cap;
        logic        ovf;
        logic        ext_q;
    } tmr16_inst_s;
    typedef struct packed {
        tmr16_inst_s [`TMR16_N-1:0] inst;
        logic        aw_got;
        tmr16_addr_t aw_addr;
        logic        w_got;
        tmr16_byte_t w_byte;
        logic        w_en;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tmr16_top_s;
endpackage

// ### tmr16_top.sv
// three 16-bit timer counter units behind an axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module tmr16_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire tmr16_pkg::tmr16_addr_t s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output wire logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output wire logic                   s_axi_wready,
    output wire logic [1:0]             s_axi_bresp,
    output wire logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire tmr16_pkg::tmr16_addr_t s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output wire logic                   s_axi_arready,
    output wire logic [31:0]            s_axi_rdata,
    output wire logic [1:0]             s_axi_rresp,
    output wire logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [3:0]             presc_tick,
    input  wire logic [`TMR16_N-1:0]    ext_clk_pin,
    input  wire logic [`TMR16_N-1:0]    capture_strobe,
    input  wire logic [`TMR16_N-1:0]    overflow_ack,
    output wire tmr16_pkg::tmr16_word_t [`TMR16_N-1:0] counter_value,
    output wire tmr16_pkg::tmr16_word_t [`TMR16_N-1:0] compare_a_value,
    output wire tmr16_pkg::tmr16_word_t [`TMR16_N-1:0] compare_b_value,
    output wire tmr16_pkg::tmr16_word_t [`TMR16_N-1:0] capture_value,
    output wire tmr16_pkg::tmr16_mode_t [`TMR16_N-1:0] waveform_mode_bits,
    output wire tmr16_pkg::tmr16_byte_t [`TMR16_N-1:0] timer_control_a,
    output wire tmr16_pkg::tmr16_byte_t [`TMR16_N-1:0] timer_control_b,
    output wire logic [`TMR16_N-1:0]    top_reached,
    output wire logic [`TMR16_N-1:0]    zero_reached,
    output wire logic [`TMR16_N-1:0]    overflow_flag
);
    import tmr16_pkg::*;

    localparam int N = `TMR16_N;

    tmr16_top_s  st_reg;
    tmr16_top_s  st_next;
    tmr16_word_t cnt_w    [N];
    logic        ovf_w    [N];
    logic        load_v   [N];
    tmr16_word_t load_val [N];

    // decoded bus requests
    tmr16_reg_e  rd_reg;
    tmr16_reg_e  wr_reg;
    logic [1:0]  rd_idx;
    logic [1:0]  wr_idx;
    logic        do_rd;
    logic        do_wr;

    tmr16_if cif [N] ();

    // the index field holds four units at most
    if (N < 1 || N > 4) begin : g_chk
        $error("unit count must be 1 to 4");
    end

    ////////////////////////////////////////////////////////////////////////
    // address helpers

    // unit index from the address
    function automatic logic [1:0] dec_idx(input tmr16_addr_t a);
        dec_idx = a[`TMR16_AW-1:`TMR16_IDX_LSB];
    endfunction

    // register selected by an address, none when unmapped
    function automatic tmr16_reg_e dec_reg(input tmr16_addr_t a);
        logic [5:0] ofs;
        ofs = a[5:0];

        if (int'(dec_idx(a)) >= N) begin
            dec_reg = REG_NONE;
        end else begin

            case (ofs)
                `TMR16_OFS_CTRL_A: dec_reg = REG_CTRL_A;
                `TMR16_OFS_CTRL_B: dec_reg = REG_CTRL_B;
                `TMR16_OFS_CNT_L:  dec_reg = REG_CNT_L;
                `TMR16_OFS_CNT_H:  dec_reg = REG_CNT_H;
                `TMR16_OFS_CMPA_L: dec_reg = REG_CMPA_L;
                `TMR16_OFS_CMPA_H: dec_reg = REG_CMPA_H;
                `TMR16_OFS_CMPB_L: dec_reg = REG_CMPB_L;
                `TMR16_OFS_CMPB_H: dec_reg = REG_CMPB_H;
                `TMR16_OFS_CAP_L:  dec_reg = REG_CAP_L;
                `TMR16_OFS_CAP_H:  dec_reg = REG_CAP_H;
                `TMR16_OFS_FLAG:   dec_reg = REG_FLAG;
                default:           dec_reg = REG_NONE;
            endcase
        end
    endfunction

    // tick picked by the clock select field
    function automatic logic sel_tick(
        input logic [2:0] cs,
        input logic [3:0] pre,
        input logic       pin,
        input logic       pin_q
    );

        case (cs)
            `TMR16_CS_STOP: sel_tick = 1'b0;
            `TMR16_CS_SYS:  sel_tick = 1'b1;
            `TMR16_CS_FALL: sel_tick = pin_q && !pin;
            `TMR16_CS_RISE: sel_tick = pin && !pin_q;
            default:        sel_tick = pre[2'(cs - `TMR16_CS_PRE)];
        endcase
    endfunction

    // byte in the low read lane
    function automatic logic [31:0] rd_word(input tmr16_byte_t b);
        rd_word = {24'h000000, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // counter units and their wiring
    for (genvar g = 0; g < N; g++) begin : g_unit
        tmr16_counter u_cnt (
            .aclk    (aclk),
            .aresetn (aresetn),
            .cif     (cif[g])
        );

        // tick select, stopped when the field is zero
        assign cif[g].tick = sel_tick(st_reg.inst[g].ctrl_b[`TMR16_CS_LSB +: 3],
                                      presc_tick, ext_clk_pin[g],
                                      st_reg.inst[g].ext_q);
        // mode split over the two control bytes
        assign cif[g].mode = {st_reg.inst[g].ctrl_b[`TMR16_WGM_HI_LSB +: 2],
                              st_reg.inst[g].ctrl_a[`TMR16_WGM_LO_LSB +: 2]};

        assign cif[g].cmp_a    = st_reg.inst[g].cmp_a;
        assign cif[g].load     = load_v[g];
        assign cif[g].load_val = load_val[g];

        assign cnt_w[g]        = cif[g].cnt;
        assign ovf_w[g]        = cif[g].ovf_evt;

        // per-unit outputs
        assign counter_value[g]      = cif[g].cnt;
        assign compare_a_value[g]    = st_reg.inst[g].cmp_a;
        assign compare_b_value[g]    = st_reg.inst[g].cmp_b;
        assign capture_value[g]      = st_reg.inst[g].cap;

        assign waveform_mode_bits[g] = cif[g].mode;
        assign timer_control_a[g]    = st_reg.inst[g].ctrl_a;
        assign timer_control_b[g]    = st_reg.inst[g].ctrl_b;

        assign top_reached[g]        = cif[g].top_hit;
        assign zero_reached[g]       = cif[g].zero_hit;
        assign overflow_flag[g]      = st_reg.inst[g].ovf;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes
    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;

    // answers straight from registers
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    // read and write decode
    always_comb begin
        do_rd  = s_axi_arvalid && !st_reg.rvalid;
        do_wr  = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        rd_reg = dec_reg(s_axi_araddr);
        rd_idx = dec_idx(s_axi_araddr);
        wr_reg = dec_reg(st_reg.aw_addr);
        wr_idx = dec_idx(st_reg.aw_addr);
    end

    // counter load strobes
    always_comb begin
        for (int k = 0; k < N; k++) begin
            load_v[k]   = do_wr && st_reg.w_en && wr_reg == REG_CNT_L
                          && int'(wr_idx) == k;
            load_val[k] = {st_reg.inst[k].temp, st_reg.w_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of registers and bus slave
    always_comb begin
        st_next = st_reg;

        // per-unit hardware events
        for (int k = 0; k < N; k++) begin
            st_next.inst[k].ext_q = ext_clk_pin[k];

            if (capture_strobe[k]) begin
                st_next.inst[k].cap = cnt_w[k];
            end

            if (overflow_ack[k]) begin
                st_next.inst[k].ovf = 1'b0;
            end
        end

        // channel acceptance
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end

        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got  = 1'b1;
            st_next.w_byte = s_axi_wdata[7:0];
            st_next.w_en   = s_axi_wstrb[0];
        end

        // responses taken
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // read: data answered one cycle after address taken
        if (do_rd) begin

            st_next.rvalid = 1'b1;
            st_next.rresp  = (rd_reg == REG_NONE) ? `TMR16_SLVERR : `TMR16_OKAY;
            st_next.rdata  = 32'h00000000;

            case (rd_reg)
                REG_CTRL_A: st_next.rdata = rd_word(st_reg.inst[rd_idx].ctrl_a);
                REG_CTRL_B: st_next.rdata = rd_word(st_reg.inst[rd_idx].ctrl_b);
                REG_CNT_L: begin
                    st_next.rdata = rd_word(cnt_w[rd_idx][7:0]);
                    st_next.inst[rd_idx].temp = cnt_w[rd_idx][15:8];
                end
                REG_CNT_H: st_next.rdata = rd_word(st_reg.inst[rd_idx].temp);

                REG_CMPA_L: st_next.rdata = rd_word(st_reg.inst[rd_idx].cmp_a[7:0]);
                REG_CMPA_H: st_next.rdata = rd_word(st_reg.inst[rd_idx].cmp_a[15:8]);
                REG_CMPB_L: st_next.rdata = rd_word(st_reg.inst[rd_idx].cmp_b[7:0]);
                REG_CMPB_H: st_next.rdata = rd_word(st_reg.inst[rd_idx].cmp_b[15:8]);

                REG_CAP_L: begin
                    st_next.rdata = rd_word(st_reg.inst[rd_idx].cap[7:0]);
                    st_next.inst[rd_idx].temp = st_reg.inst[rd_idx].cap[15:8];
                end
                REG_CAP_H: st_next.rdata = rd_word(st_reg.inst[rd_idx].temp);

                REG_FLAG: st_next.rdata = rd_word({7'h00, st_reg.inst[rd_idx].ovf});
                default: st_next.rdata = 32'h00000000;
            endcase
        end

        // write: committed once address and data are both held
        if (do_wr) begin

            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = (wr_reg == REG_NONE) ? `TMR16_SLVERR : `TMR16_OKAY;

            // only byte lane 0 is stored
            if (st_reg.w_en) begin
                case (wr_reg)
                    REG_CTRL_A: st_next.inst[wr_idx].ctrl_a = st_reg.w_byte;
                    REG_CTRL_B: st_next.inst[wr_idx].ctrl_b = st_reg.w_byte;

                    REG_CNT_H,
                    REG_CMPA_H,
                    REG_CMPB_H,
                    REG_CAP_H: st_next.inst[wr_idx].temp = st_reg.w_byte;

                    REG_CMPA_L: st_next.inst[wr_idx].cmp_a = {st_reg.inst[wr_idx].temp, st_reg.w_byte};
                    REG_CMPB_L: st_next.inst[wr_idx].cmp_b = {st_reg.inst[wr_idx].temp, st_reg.w_byte};
                    REG_CAP_L: st_next.inst[wr_idx].cap = {st_reg.inst[wr_idx].temp, st_reg.w_byte};

                    REG_FLAG: begin
                        if (st_reg.w_byte[`TMR16_OVF_BIT]) begin
                            st_next.inst[wr_idx].ovf = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // overflow event set wins over any clear
        for (int k = 0; k < N; k++) begin
            if (ovf_w[k]) begin
                st_next.inst[k].ovf = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ### tmr16_top_assertions.sv
// port-level checks of the timer block
`timescale 1ns/100ps
module tmr16_top_assertions (
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire tmr16_pkg::tmr16_addr_t       s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic [31:0]                  s_axi_wdata,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic                         s_axi_bvalid,
    input wire tmr16_pkg::tmr16_addr_t       s_axi_araddr,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire logic [2:0]                   overflow_ack,
    input wire tmr16_pkg::tmr16_word_t [2:0] counter_value,
    input wire tmr16_pkg::tmr16_word_t [2:0] compare_a_value,
    input wire tmr16_pkg::tmr16_mode_t [2:0] waveform_mode_bits,
    input wire tmr16_pkg::tmr16_byte_t [2:0] timer_control_b,
    input wire logic [2:0]                   top_reached,
    input wire logic [2:0]                   zero_reached,
    input wire logic [2:0]                   overflow_flag
);
    import tmr16_pkg::*;
    localparam logic [15:0] TOPA = `TMR16_TOPA_MASK;
    logic [15:0] cnt_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // previous count of unit 0
    always_ff @(posedge aclk) cnt_q <= counter_value[0];
    // both write channels taken at one edge
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    sequence lo_wr;
        wr_take && s_axi_awaddr == 8'h08;
    endsequence
    sequence hi_wr;
        wr_take && s_axi_awaddr == 8'h0C && timer_control_b[0][2:0] == 3'h0;
    endsequence
    ////////////////////////////////////////////////////////////
    a_zero_match: assert property (zero_reached == {counter_value[2] == 16'h0000,
        counter_value[1] == 16'h0000, counter_value[0] == 16'h0000}) else $error("zero flag wrong");
    a_top_match: assert property (top_reached[0] == (counter_value[0] ==
        (TOPA[waveform_mode_bits[0]] ? compare_a_value[0] : 16'hFFFF))) else $error("top flag wrong");
    a_stop_holds: assert property ($changed(counter_value[0]) && $past(timer_control_b[0][2:0]) == 3'h0
        |-> $rose(s_axi_bvalid)) else $error("stopped counter moved");
    a_ack_clears: assert property (overflow_ack[1] && timer_control_b[1][2:0] == 3'h0
        |=> !overflow_flag[1]) else $error("ack did not clear flag");
    a_ovf_on_tick: assert property ($rose(overflow_flag[0])
        |-> $changed(counter_value[0]) || $changed(cnt_q)) else $error("flag rose without count");
    a_high_latch_only: assert property (hi_wr |-> ##1 $stable(counter_value[0]) [*3])
        else $error("high write moved count");
    a_low_write_load: assert property (lo_wr |-> ##2 counter_value[0][7:0] == $past(s_axi_wdata[7:0], 2))
        else $error("low write not loaded");
    a_low_read_now: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08
        |=> s_axi_rdata[7:0] == $past(counter_value[0][7:0])) else $error("low read wrong");
endmodule
bind tmr16_top tmr16_top_assertions u_chk (.*);
